/* File: verilog/walker_pkg.sv */
// Shared constants, field layouts and carriers of the translation walker
package walker_pkg;

  localparam int VA_W = 64;
  localparam int PA_W = 56;
  localparam int PPN_W = 44;
  localparam int OFS_W = 12;
  localparam int SLICE_W = 9;
  localparam int ENTRY_SIZE_BYTES = 8;
  localparam int ENTRY_SHIFT = 3;

  // Translation mode codes held in the mode register
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_39 = 4'h8;
  localparam logic [3:0] MODE_48 = 4'h9;
  localparam logic [3:0] MODE_57 = 4'hA;

  localparam logic [2:0] LEVELS_39 = 3'h3;
  localparam logic [2:0] LEVELS_48 = 3'h4;
  localparam logic [2:0] LEVELS_57 = 3'h5;

  // Left shift that drops the bits above the sign bit of each scheme
  localparam logic [5:0] CANON_SH_39 = 6'h19;
  localparam logic [5:0] CANON_SH_48 = 6'h10;
  localparam logic [5:0] CANON_SH_57 = 6'h07;

  // Flag bit positions
  localparam int BIT_V = 0;
  localparam int BIT_R = 1;
  localparam int BIT_W = 2;
  localparam int BIT_X = 3;

  localparam logic [3:0] CONTIG_PATTERN = 4'h8;
  localparam logic [1:0] MT_RESERVED = 2'h3;

  // Register byte offsets and reset values
  localparam logic [11:0] REG_MODE = 12'h000;
  localparam logic [11:0] REG_ROOT_LO = 12'h004;
  localparam logic [11:0] REG_ROOT_HI = 12'h008;
  localparam logic [11:0] REG_STATUS = 12'h00C;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [43:0] ROOT_RESET = 44'h000_0000_0000;

  typedef enum logic [1:0] {ACC_FETCH, ACC_LOAD, ACC_STORE} access_t;

  typedef struct packed {
    access_t kind;
    logic [63:0] vaddr;
  } xlat_req_t;

  typedef struct packed {
    logic fault;
    logic [55:0] paddr;
    logic [7:0] flags;
    logic [1:0] memory_type_field;
    logic [1:0] software_reserved_field;
  } xlat_rsp_t;

  typedef struct packed {
    logic contig;
    logic [1:0] memory_type_field;
    logic [6:0] reserved;
    logic [43:0] ppn;
    logic [1:0] software_reserved_field;
    logic [7:0] flags;
  } entry_t;

  function automatic logic [2:0] levels_of(input logic [3:0] mode);
    case (mode)
      MODE_39: levels_of = LEVELS_39;
      MODE_48: levels_of = LEVELS_48;
      MODE_57: levels_of = LEVELS_57;
      default: levels_of = 3'h0;
    endcase
  endfunction : levels_of

  function automatic logic [8:0] vpn_slice(input logic [63:0] va,
                                           input logic [2:0] lvl);
    logic [63:0] sh;
    sh = va >> (OFS_W + SLICE_W * int'(lvl));
    vpn_slice = sh[8:0];
  endfunction : vpn_slice

endpackage : walker_pkg

/* File: verilog/entry_check.sv */
// Decode and fault check of one fetched table entry
`timescale 1ns/10ps
`default_nettype none
module entry_check #(
  parameter bit HAS_CONTIG = 1'b1,
  parameter bit HAS_MEMTYPE = 1'b1
) (
  input wire walker_pkg::entry_t entry,
  input wire logic [2:0] level,
  input wire logic [3:0] vpn_nibble,
  output logic leaf,
  output logic fault,
  output logic [43:0] low_mask,
  output logic [43:0] ppn_fixed
);

  logic valid_bit;
  logic rd_bit;
  logic wr_bit;
  logic ex_bit;
  logic bad_perm;
  logic res_future;
  logic res_contig;
  logic res_memtype;
  logic misaligned;
  logic contig_bad;
  logic [5:0] low_bits;

  assign valid_bit = entry.flags[walker_pkg::BIT_V];
  assign rd_bit = entry.flags[walker_pkg::BIT_R];
  assign wr_bit = entry.flags[walker_pkg::BIT_W];
  assign ex_bit = entry.flags[walker_pkg::BIT_X];

  assign leaf = rd_bit | ex_bit; // R23
  assign bad_perm = !valid_bit | (!rd_bit & wr_bit);
  assign res_future = |entry.reserved; // R08
  assign res_contig = !HAS_CONTIG & entry.contig; // R06
  // Leaf may carry a type, pointer may not; code 3 stays reserved
  assign res_memtype = HAS_MEMTYPE ?
    (leaf ? (entry.memory_type_field == walker_pkg::MT_RESERVED)
          : (|entry.memory_type_field))
    : (|entry.memory_type_field); // R07

  // Lower slices of a large page must be zero
  assign low_bits = 6'({3'h0, level} * 6'h09);
  assign low_mask = (44'h001 << low_bits) - 44'h001; // R19
  assign misaligned = leaf & (level != 3'h0)
                      & (|(entry.ppn & low_mask)); // R09 R14 R20 R24

  // Only the 64 KiB range at the last level is a valid encoding
  assign contig_bad = HAS_CONTIG & entry.contig
                      & (!leaf | (level != 3'h0)
                         | (entry.ppn[3:0] != walker_pkg::CONTIG_PATTERN));
  // R25 R21
  assign ppn_fixed = (HAS_CONTIG & entry.contig) ?
                     {entry.ppn[43:4], vpn_nibble} : entry.ppn; // R26

  assign fault = bad_perm | res_future | res_contig | res_memtype
                 | misaligned | contig_bad;

endmodule : entry_check
`default_nettype wire

/* File: verilog/page_walker.sv */
// Page table walker with address checks and an APB configuration slave
//
// Overview of operation
// R01 - 39-bit scheme faults when address bits 63..39 differ from bit 38.
// R02 - 39-bit scheme maps 27-bit page number via three levels.
// R03 - Entry splits into page number slices, software field and flags.
// R04 - Tables are one page of 512 entries; root comes from register.
// R05 - 39-bit scheme walks three levels reading eight-byte entries.
// R06 - Without contiguity support, entry bit 63 set faults.
// R07 - Without memory-type support, entry bits 62..61 set fault.
// R08 - Any set bit among 60..54 faults.
// R09 - Leaves at any level; misaligned large page faults.
// R10 - 48-bit scheme faults when bits 63..48 differ from bit 47.
// R11 - 48-bit scheme maps 36-bit page number via four levels.
// R12 - 48-bit scheme walks four levels with eight-byte entries.
// R13 - Offering the 48-bit scheme implies offering the 39-bit one.
// R14 - 48-bit entries decode as 39-bit ones; misaligned leaves fault.
// R15 - 57-bit scheme faults when bits 63..57 differ from bit 56.
// R16 - 57-bit scheme maps 45-bit page number via five levels.
// R17 - 57-bit scheme walks five levels with eight-byte entries.
// R18 - Offering the 57-bit scheme implies offering the 48-bit one.
// R19 - 57-bit top slice is bits 53..46, next 45..37, then 9-bit.
// R20 - 57-bit leaves allowed at all five levels; misaligned faults.
// R21 - Contiguity flag marks part of an aligned power-of-two range.
// R22 - Contiguity support exists only alongside the 39-bit scheme.
// R23 - Read or execute set means leaf; past level zero faults.
// R24 - Leaf above level zero with nonzero lower slices faults.
// R25 - Contiguous entry low nibble must be 1000, else fault.
// R26 - Valid contiguous entry takes its low bits from the address.
// R27 - Software-set mode picks levels and address check width.
// R28 - Success returns physical address, flags and memory type.
`timescale 1ns/10ps
`default_nettype none
module page_walker #(
  parameter int MAX_LEVELS = 5,
  parameter bit HAS_CONTIG = 1'b1,
  parameter bit HAS_MEMTYPE = 1'b1
) (
  input wire logic ref_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Translation request and answer
  input wire logic req_valid,
  output logic req_ready,
  input wire walker_pkg::xlat_req_t req,
  output logic rsp_valid,
  output walker_pkg::xlat_rsp_t rsp,
  // Entry reads towards memory
  output logic mem_req_valid,
  input wire logic mem_req_ready,
  output logic [55:0] mem_req_addr,
  input wire logic mem_rsp_valid,
  input wire walker_pkg::entry_t mem_rsp_data
);

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} state_t;

  state_t state_q;
  state_t state_d;
  logic [3:0] mode_q;
  logic [43:0] root_q;
  logic [63:0] vaddr_q;
  logic [2:0] level_q;
  logic [55:0] mem_addr_q;
  logic rsp_valid_q;
  walker_pkg::xlat_rsp_t rsp_q;
  logic last_fault_q;
  logic [31:0] prdata_q;

  // APB decode
  wire apb_setup = psel & !penable;
  wire apb_access = psel & penable;
  wire hit_mode = (paddr == walker_pkg::REG_MODE);
  wire hit_root_lo = (paddr == walker_pkg::REG_ROOT_LO);
  wire hit_root_hi = (paddr == walker_pkg::REG_ROOT_HI);
  wire hit_status = (paddr == walker_pkg::REG_STATUS);
  wire addr_hit = hit_mode | hit_root_lo | hit_root_hi | hit_status;
  wire wr_mode = apb_access & pwrite & hit_mode;
  wire wr_root_lo = apb_access & pwrite & hit_root_lo;
  wire wr_root_hi = apb_access & pwrite & hit_root_hi;

  // Larger schemes imply all smaller ones
  wire [3:0] mode_new = pwdata[3:0];
  wire mode_legal = (mode_new == walker_pkg::MODE_OFF)
    | (mode_new == walker_pkg::MODE_39) // R22
    | ((mode_new == walker_pkg::MODE_48) & (MAX_LEVELS >= 4))
    | ((mode_new == walker_pkg::MODE_57) & (MAX_LEVELS >= 5)); // R13 R18

  wire busy = (state_q != ST_IDLE);
  wire [31:0] status_word = {24'h000000, busy, last_fault_q, 3'h0,
                             level_q};
  wire [31:0] read_word =
    hit_mode ? {28'h0000000, mode_q} :
    hit_root_lo ? root_q[31:0] :
    hit_root_hi ? {20'h00000, root_q[43:32]} :
    hit_status ? status_word : 32'h00000000;

  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = apb_access & !addr_hit;

  // Scheme in force picks levels and the sign-bit position
  wire [2:0] levels = walker_pkg::levels_of(mode_q); // R27
  wire [5:0] canon_sh =
    (mode_q == walker_pkg::MODE_39) ? walker_pkg::CANON_SH_39 :
    (mode_q == walker_pkg::MODE_48) ? walker_pkg::CANON_SH_48 :
    walker_pkg::CANON_SH_57; // R27
  wire [63:0] canon_shl = req.vaddr << canon_sh;
  wire [63:0] canon_ext = 64'($signed(canon_shl) >>> canon_sh);
  wire canon_ok = (canon_ext == req.vaddr); // R01 R10 R15
  wire mode_off = (mode_q == walker_pkg::MODE_OFF);
  wire accept = req_valid & req_ready;
  wire [2:0] top_level = levels - 3'h1;

  // Entry decode of the current answer
  logic chk_leaf;
  logic chk_fault;
  logic [43:0] chk_mask;
  logic [43:0] chk_ppn;

  entry_check #(
    .HAS_CONTIG(HAS_CONTIG),
    .HAS_MEMTYPE(HAS_MEMTYPE)
  ) u_check (
    .entry(mem_rsp_data),
    .level(level_q),
    .vpn_nibble(vaddr_q[15:12]),
    .leaf(chk_leaf),
    .fault(chk_fault),
    .low_mask(chk_mask),
    .ppn_fixed(chk_ppn)
  );

  wire got_entry = (state_q == ST_WAIT) & mem_rsp_valid;
  wire past_last = !chk_leaf & (level_q == 3'h0); // R23
  wire walk_fault = got_entry & (chk_fault | past_last);
  wire walk_leaf = got_entry & !chk_fault & chk_leaf;
  wire descend = got_entry & !chk_fault & !chk_leaf & !past_last;
  wire [2:0] next_level = level_q - 3'h1;

  // Large pages take their lower slices from the address
  wire [43:0] vpn_bits = vaddr_q[55:12];
  wire [43:0] leaf_ppn = (chk_ppn & ~chk_mask)
                         | (vpn_bits & chk_mask); // R02 R11 R16 R19

  // Root table address, then each pointer names the next table
  wire [55:0] root_addr = {root_q, walker_pkg::vpn_slice(req.vaddr,
                           top_level), 3'h0}; // R04 R05 R12 R17
  wire [55:0] next_addr = {mem_rsp_data.ppn, walker_pkg::vpn_slice(
                           vaddr_q, next_level), 3'h0}; // R04

  wire canon_fault = accept & !mode_off & !canon_ok;
  wire bare_done = accept & mode_off;
  wire respond = canon_fault | bare_done | walk_fault | walk_leaf;

  walker_pkg::xlat_rsp_t rsp_d;
  always_comb begin
    rsp_d = '0;
    if (bare_done) begin
      rsp_d.paddr = req.vaddr[55:0];
    end else if (canon_fault | walk_fault) begin
      rsp_d.fault = 1'b1; // R01 R10 R15
    end else begin
      rsp_d.paddr = {leaf_ppn, vaddr_q[11:0]}; // R02 R28
      rsp_d.flags = mem_rsp_data.flags; // R03 R28
      rsp_d.memory_type_field = mem_rsp_data.memory_type_field; // R28
      rsp_d.software_reserved_field =
        mem_rsp_data.software_reserved_field; // R03
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (accept & !mode_off & canon_ok) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (mem_req_ready) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (descend) begin
          state_d = ST_FETCH;
        end else if (walk_fault | walk_leaf) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  assign req_ready = (state_q == ST_IDLE);
  assign mem_req_valid = (state_q == ST_FETCH);
  assign mem_req_addr = mem_addr_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp = rsp_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q <= walker_pkg::MODE_RESET;
      root_q <= walker_pkg::ROOT_RESET;
      prdata_q <= 32'h00000000;
    end else begin
      if (wr_mode & mode_legal) begin
        mode_q <= mode_new;
      end
      if (wr_root_lo) begin
        root_q[31:0] <= pwdata;
      end
      if (wr_root_hi) begin
        root_q[43:32] <= pwdata[11:0];
      end
      if (apb_setup) begin
        prdata_q <= read_word;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      vaddr_q <= 64'h0000000000000000;
      level_q <= 3'h0;
      mem_addr_q <= 56'h00000000000000;
    end else begin
      state_q <= state_d;
      if (accept) begin
        vaddr_q <= req.vaddr;
        level_q <= top_level; // R05 R12 R17 R27
        mem_addr_q <= root_addr;
      end else if (descend) begin
        level_q <= next_level; // R23
        mem_addr_q <= next_addr;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
      last_fault_q <= 1'b0;
    end else begin
      rsp_valid_q <= respond;
      if (respond) begin
        rsp_q <= rsp_d;
        last_fault_q <= rsp_d.fault;
      end
    end
  end

  // Checks
  wire nc39 = req.vaddr[63:38] != {26{req.vaddr[38]}};
  wire nc48 = req.vaddr[63:47] != {17{req.vaddr[47]}};
  wire nc57 = req.vaddr[63:56] != {8{req.vaddr[56]}};
  wire res_set = |mem_rsp_data.reserved;

  sequence s_bad_entry;
    got_entry && res_set;
  endsequence

  sequence s_fault_out;
    rsp_valid && rsp.fault;
  endsequence

  a_canon_39_fault: assert property ( // R01
    @(posedge ref_clk) disable iff (rst)
    accept && mode_q == walker_pkg::MODE_39 && nc39 |=> s_fault_out)
    else $error("noncanonical 39-bit address not faulted");

  a_canon_48_fault: assert property ( // R10
    @(posedge ref_clk) disable iff (rst)
    accept && mode_q == walker_pkg::MODE_48 && nc48 |=> s_fault_out)
    else $error("noncanonical 48-bit address not faulted");

  a_canon_57_fault: assert property ( // R15
    @(posedge ref_clk) disable iff (rst)
    accept && mode_q == walker_pkg::MODE_57 && nc57 |=> s_fault_out)
    else $error("noncanonical 57-bit address not faulted");

  a_reserved_bits_fault: assert property ( // R08
    @(posedge ref_clk) disable iff (rst)
    s_bad_entry |=> s_fault_out ##0 (rsp.flags == 8'h00))
    else $error("reserved entry bits did not fault");

  a_root_first_read: assert property ( // R04
    @(posedge ref_clk) disable iff (rst)
    accept && !mode_off && canon_ok
    |=> mem_req_valid && mem_req_addr[55:12] == $past(root_q))
    else $error("first read not from root table");

  a_entry_aligned: assert property ( // R05
    @(posedge ref_clk) disable iff (rst)
    mem_req_valid |-> mem_req_addr[2:0] == 3'h0)
    else $error("entry read not eight-byte aligned");

  a_level_start: assert property ( // R27
    @(posedge ref_clk) disable iff (rst)
    accept && mode_q == walker_pkg::MODE_57 && !nc57
    |=> level_q == 3'h4)
    else $error("57-bit walk did not start at level four");

  a_offset_pass: assert property ( // R02
    @(posedge ref_clk) disable iff (rst)
    rsp_valid && !rsp.fault && !mode_off
    |-> rsp.paddr[11:0] == vaddr_q[11:0])
    else $error("page offset changed by translation");

  a_read_held: assert property ( // R12
    @(posedge ref_clk) disable iff (rst)
    mem_req_valid && !mem_req_ready
    |=> mem_req_valid && $stable(mem_req_addr))
    else $error("entry read dropped before acceptance");

  a_past_zero_fault: assert property ( // R23
    @(posedge ref_clk) disable iff (rst)
    got_entry && level_q == 3'h0 && !chk_leaf |=> s_fault_out)
    else $error("pointer at level zero not faulted");

endmodule : page_walker
`default_nettype wire

/* File: test/mem_model.sv */
// Memory model serving table entry reads to the walker
`timescale 1ns/10ps
`default_nettype none
module mem_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic mem_req_valid,
  output logic mem_req_ready,
  input wire logic [55:0] mem_req_addr,
  output logic mem_rsp_valid,
  output walker_pkg::entry_t mem_rsp_data
);
  logic [63:0] mem [logic [55:0]];
  logic [55:0] a_q;
  logic busy = 1'b0;
  int lat = 0;
  int stall = 0;
  int w = 0;
  int cnt = 0;

  task automatic put(input logic [55:0] a, input logic [63:0] d);
    mem[a] = d;
  endtask : put

  task automatic clear();
    mem.delete();
  endtask : clear

  // Optional stall before a read is accepted
  assign mem_req_ready = !busy && w >= stall;

  always @(posedge ref_clk) begin
    mem_rsp_valid <= 1'b0;
    // Data churns outside the answer pulse
    mem_rsp_data <= walker_pkg::entry_t'(~mem_rsp_data);
    if (rst) begin
      busy <= 1'b0;
      w <= 0;
      mem_rsp_data <= '0;
    end else if (busy && cnt == 0) begin
      busy <= 1'b0;
      mem_rsp_valid <= 1'b1;
      mem_rsp_data <= mem.exists(a_q) ? mem[a_q] : 64'h0;
    end else if (busy) begin
      cnt <= cnt - 1;
    end else if (mem_req_valid && mem_req_ready) begin
      busy <= 1'b1;
      a_q <= mem_req_addr;
      cnt <= lat;
      w <= 0;
    end else if (mem_req_valid) begin
      w <= w + 1;
    end
  end
endmodule : mem_model
`default_nettype wire

/* File: test/paged_address_translation_walker_tb_top.sv */
// Self-checking bench for the page table walker
`timescale 1ns/10ps
`default_nettype none
module paged_address_translation_walker_tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic req_valid = 1'b0;
  logic req_ready;
  walker_pkg::xlat_req_t req = '0;
  logic rsp_valid;
  walker_pkg::xlat_rsp_t rsp;
  logic mem_req_valid;
  logic mem_req_ready;
  logic [55:0] mem_req_addr;
  logic mem_rsp_valid;
  walker_pkg::entry_t mem_rsp_data;
  int fail_count = 0;
  int n_compared = 0;

  always #20 ref_clk = ~ref_clk;

  page_walker page_walker_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .rsp_valid(rsp_valid), .rsp(rsp), .mem_req_valid(mem_req_valid),
    .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
    .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));

  mem_model mem_model_inst (.ref_clk(ref_clk), .rst(rst),
    .mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready),
    .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid),
    .mem_rsp_data(mem_rsp_data));

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write pslverr", 64'h0, e);
  endtask : wreg

  task automatic cfg(input logic [3:0] md, input logic [43:0] root);
    wreg(walker_pkg::REG_ROOT_LO, root[31:0]);
    wreg(walker_pkg::REG_ROOT_HI, {20'h0, root[43:32]});
    wreg(walker_pkg::REG_MODE, {28'h0, md});
  endtask : cfg

  task automatic xlate(input logic [63:0] va,
                       output walker_pkg::xlat_rsp_t r);
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req <= '{kind: walker_pkg::ACC_LOAD, vaddr: va};
    #1;
    while (req_ready !== 1'b1) @(posedge ref_clk) #1;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    while (rsp_valid !== 1'b1) @(posedge ref_clk) #1;
    r = rsp;
  endtask : xlate

  function automatic logic [8:0] vs(input logic [63:0] va, input int l);
    return va[12 + 9 * l +: 9];
  endfunction : vs

  function automatic logic [63:0] pe(input logic [43:0] p);
    return {10'h000, p, 10'h001};
  endfunction : pe

  function automatic logic [63:0] le(input logic [43:0] p,
                                     input logic [1:0] mt);
    return {1'b0, mt, 7'h00, p, 2'h2, 8'hCF};
  endfunction : le

  function automatic logic [55:0] xp(input logic [43:0] p,
                                     input logic [63:0] va, input int l);
    logic [43:0] m;
    m = (44'h1 << (9 * l)) - 44'h1;
    return {(p & ~m) | (va[55:12] & m), va[11:0]};
  endfunction : xp

  // Tables of level l live at page 0x100 + l
  task automatic build(input int lv, input int lf, input logic [63:0] va,
                       input logic [63:0] leaf);
    logic [43:0] t;
    mem_model_inst.clear();
    for (int l = lv - 1; l >= lf; l--) begin
      t = 44'h100 + 44'(l);
      mem_model_inst.put({t, vs(va, l), 3'h0},
                         l == lf ? leaf : pe(t - 44'h1));
    end
  endtask : build

  task automatic t_regs();
    logic [31:0] d;
    logic e;
    apb(1'b0, walker_pkg::REG_MODE, 32'h0, d, e);
    chk("mode reset", 64'h0, d[3:0]);
    wreg(walker_pkg::REG_MODE, 32'h0000_0009);
    wreg(walker_pkg::REG_MODE, 32'h0000_0003);
    apb(1'b0, walker_pkg::REG_MODE, 32'h0, d, e);
    chk("mode", 64'h9, d[3:0]);
    wreg(walker_pkg::REG_ROOT_HI, 32'hFFFF_FABC);
    apb(1'b0, walker_pkg::REG_ROOT_HI, 32'h0, d, e);
    chk("root hi", 64'hABC, d[11:0]);
    apb(1'b1, 12'h010, 32'h0000_0001, d, e);
    chk("unmapped write", 64'h1, e);
    apb(1'b0, 12'h010, 32'h0, d, e);
    chk("unmapped read", 64'h0, d);
    apb(1'b0, walker_pkg::REG_STATUS, 32'h0, d, e);
    chk("idle busy", 64'h0, d[7]);
  endtask : t_regs

  task automatic t_off();
    walker_pkg::xlat_rsp_t r;
    cfg(walker_pkg::MODE_OFF, 44'h0);
    xlate(64'hFEDC_BA98_7654_3210, r);
    chk("off paddr", 64'hDC_BA98_7654_3210, r.paddr);
  endtask : t_off

  task automatic t_walk();
    logic [3:0] md[3];
    logic [63:0] va;
    logic [43:0] p;
    walker_pkg::xlat_rsp_t r;
    int lv;
    md = '{walker_pkg::MODE_39, walker_pkg::MODE_48, walker_pkg::MODE_57};
    for (int i = 0; i < 3; i++) begin
      lv = i + 3;
      va = (~64'h0 << (38 + 9 * i)) | 64'h4567_3ABC;
      mem_model_inst.lat = i;
      mem_model_inst.stall = i;
      cfg(md[i], 44'h100 + 44'(lv - 1));
      build(lv, 0, va, le(44'h0AB_CDEF_0128, 2'h1));
      xlate(va, r);
      chk("fault", 64'h0, r.fault);
      chk("paddr", xp(44'h0AB_CDEF_0128, va, 0), r.paddr);
      chk("flags", 64'hCF, r.flags);
      chk("memory_type_field", 64'h1, r.memory_type_field);
      chk("sw field", 64'h2, r.software_reserved_field);
      p = 44'h0AB_CDEF_0128 & ~((44'h1 << (9 * (lv - 1))) - 44'h1);
      build(lv, lv - 1, va, le(p, 2'h0));
      xlate(va, r);
      chk("top leaf", xp(p, va, lv - 1), r.paddr);
      build(lv, 1, va, le(44'h0AB_CDEF_0128, 2'h0));
      xlate(va, r);
      chk("misaligned", 64'h1, r.fault);
      xlate(va ^ (64'h1 << 63), r);
      chk("bit 63", 64'h1, r.fault);
      xlate(va ^ (64'h1 << (39 + 9 * i)), r);
      chk("above sign", 64'h1, r.fault);
    end
  endtask : t_walk

  task automatic t_bits();
    logic [63:0] g;
    logic [63:0] bad[5];
    logic [63:0] va;
    walker_pkg::xlat_rsp_t r;
    logic [31:0] d;
    logic e;
    va = 64'h0000_0000_4567_3ABC;
    g = le(44'h0AB_CDEF_0128, 2'h1);
    bad = '{g | 64'h0040_0000_0000_0000, g | 64'h1000_0000_0000_0000,
            g | 64'h4000_0000_0000_0000,
            (g | 64'h8000_0000_0000_0000) ^ 64'h3000, pe(44'h155)};
    mem_model_inst.lat = 1;
    mem_model_inst.stall = 0;
    cfg(walker_pkg::MODE_39, 44'h102);
    for (int k = 0; k < 5; k++) begin
      build(3, 0, va, bad[k]);
      xlate(va, r);
      chk("bad entry", 64'h1, r.fault);
      chk("fault flags", 64'h0, r.flags);
    end
    apb(1'b0, walker_pkg::REG_STATUS, 32'h0, d, e);
    chk("last fault", 64'h1, d[6]);
    chk("fault level", 64'h0, d[2:0]);
    build(3, 0, va, g | 64'h8000_0000_0000_0000);
    xlate(va, r);
    chk("range", {8'h00, 44'h0AB_CDEF_0123, va[11:0]}, r.paddr);
    chk("range fault", 64'h0, r.fault);
  endtask : t_bits

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs();
    t_off();
    t_walk();
    t_bits();
    test_done();
  end

  // Whole run needs well under this span
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end
endmodule : paged_address_translation_walker_tb_top
`default_nettype wire
